// ---- inc/rrs_cfg.svh ----
// Constants for the return, rotate, subtract, xor and sleep executor
// Summary of operation
// RQ1 - Return-with-literal loads the 8-bit literal into acc; flags untouched.
// RQ2 - Return-with-literal reloads PC from the stack head; two cycles.
// RQ3 - Rotate right through carry: old carry to bit 7, bit 0 to carry.
// RQ4 - Rotate result goes to acc when dest is 0, file register when 1.
// RQ5 - Subroutine return pops stack, loads PC, keeps flags, takes two cycles.
// RQ6 - Sleep clears the watchdog counter to 00h and its prescaler.
// RQ7 - Sleep sets the expiry flag and clears the power-down flag.
// RQ8 - After sleep the oscillator halts and execution stops until wake.
// RQ9 - Literal minus acc into acc, updating carry, nibble carry, zero.
// RQ10 - Xor literal into acc, updating only the zero flag.
// RQ11 - Destination select is one bit: 0 to acc, 1 to file register.
// RQ12 - Subtract carries are inverted borrows, from bit 7 and bit 3.
`ifndef RRS_CFG_SVH
`define RRS_CFG_SVH

// ****************************************
// Widths
// ****************************************
`define ADDR_W         12
`define DATA_W         32
`define BYTE_W         8
`define NIB_W          4
`define PC_W           13
`define FADDR_W        7
`define OP_W           3
`define ST_W           4

// ****************************************
// Register map and fields
// ****************************************
`define ADDR_INSTR     12'h000
`define ADDR_ACC       12'h004
`define ADDR_STAT      12'h008
`define ADDR_PC        12'h00C
`define FREG_SEL_LSB   9
`define FREG_SEL       3'h1
`define FREG_IDX_LSB   2
`define INSTR_DEST_BIT 8
`define INSTR_OP_LSB   12
`define STAT_C         0
`define STAT_N         1
`define STAT_Z         2
`define STAT_PWRDN     3
`define STAT_EXP       4
`define STAT_BUSY      5
`define STAT_SLP       6
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

// ****************************************
// Encodings and reset values
// ****************************************
`define OP_NONE        3'h0
`define OP_RETLIT      3'h1
`define OP_ROTR        3'h2
`define OP_RETSUB      3'h3
`define OP_SUBLIT      3'h4
`define OP_XORLIT      3'h5
`define OP_SLEEP       3'h6
`define ST_IDLE        4'h1
`define ST_EXEC        4'h2
`define ST_SECOND      4'h4
`define ST_SLEEP       4'h8
`define ACC_RST        8'h00
`define PC_RST         13'h0000
`define EXPIRY_RST     1'b1
`define PDOWN_RST      1'b1
`define WDOG_CLR_VAL   8'h00

`endif

// ---- inc/rrs_pkg.sv ----
// Types shared by the executor and its arithmetic unit
`include "rrs_cfg.svh"
package rrs_pkg;
   typedef logic [`BYTE_W-1:0]  byte_t;
   typedef logic [`PC_W-1:0]    pc_t;
   typedef logic [`FADDR_W-1:0] faddr_t;

   typedef enum logic [`OP_W-1:0] {
      NO_OP               = `OP_NONE,
      RETURN_WITH_LITERAL = `OP_RETLIT,
      ROTATE_RIGHT_CARRY  = `OP_ROTR,
      SUB_RETURN          = `OP_RETSUB,
      LITERAL_MINUS_ACC   = `OP_SUBLIT,
      XOR_LITERAL_ACC     = `OP_XORLIT,
      SLEEP_OP            = `OP_SLEEP
   } op_e;

   typedef enum logic [`ST_W-1:0] {
      ST_IDLE   = `ST_IDLE,
      ST_EXEC   = `ST_EXEC,
      ST_SECOND = `ST_SECOND,
      ST_SLEEP  = `ST_SLEEP
   } state_e;

   typedef struct packed {
      op_e   op;
      logic  dest;
      byte_t lit;
   } instr_s;

   typedef struct packed {
      logic expiry;
      logic powerDown;
      logic zero;
      logic nibble;
      logic carry;
   } flags_s;

   typedef struct packed {
      byte_t value;
      logic  carry;
      logic  nibble;
      logic  zero;
      logic  setC;
      logic  setN;
      logic  setZ;
   } alu_s;

   function automatic logic zeroOf(input byte_t v);
      return v == `ACC_RST;
   endfunction
endpackage

// ---- core/rrs_alu.sv ----
// Arithmetic unit: result and flag updates for each operation
`timescale 1ns/1ps
`include "rrs_cfg.svh"
module rrs_alu (
   // Operation and operands
   input  wire rrs_pkg::op_e   op,
   input  wire rrs_pkg::byte_t acc,
   input  wire rrs_pkg::byte_t fileVal,
   input  wire rrs_pkg::byte_t lit,
   input  wire logic           carryIn,
   // Result with flag enables
   output rrs_pkg::alu_s       res
);
   import rrs_pkg::*;

   logic [`BYTE_W:0]  diff;
   logic [`NIB_W:0]   nibDiff;

   // Two's complement: k + ~w + 1, carry out is the inverted borrow
   assign diff    = {1'b0, lit} + {1'b0, ~acc} + {{`BYTE_W{1'b0}}, 1'b1};
   assign nibDiff = {1'b0, lit[`NIB_W-1:0]} + {1'b0, ~acc[`NIB_W-1:0]}
                  + {{`NIB_W{1'b0}}, 1'b1};

   always_comb begin
      res = '0;
      case (op)
         RETURN_WITH_LITERAL: begin
            res.value = lit; // see RQ1
         end
         ROTATE_RIGHT_CARRY: begin
            res.value = {carryIn, fileVal[`BYTE_W-1:1]}; // see RQ3
            res.carry = fileVal[0]; // see RQ3
            res.setC  = 1'b1;
         end
         LITERAL_MINUS_ACC: begin
            res.value  = diff[`BYTE_W-1:0]; // see RQ9
            res.carry  = diff[`BYTE_W]; // see RQ12
            res.nibble = nibDiff[`NIB_W]; // see RQ12
            res.zero   = zeroOf(diff[`BYTE_W-1:0]);
            res.setC   = 1'b1;
            res.setN   = 1'b1;
            res.setZ   = 1'b1;
         end
         XOR_LITERAL_ACC: begin
            res.value = acc ^ lit; // see RQ10
            res.zero  = zeroOf(acc ^ lit);
            res.setZ  = 1'b1;
         end
         default: begin
            res = '0;
         end
      endcase
   end
endmodule

// ---- core/return_rotate_sleep_exec.sv ----
// Executor for return, rotate, subtract, xor and sleep instructions
`timescale 1ns/1ps
`include "rrs_cfg.svh"
module return_rotate_sleep_exec (
   // Clock, reset, enable
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                ce,
   // AXI4-Lite write channels
   input  wire logic [`ADDR_W-1:0]  awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [`DATA_W-1:0]  wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   // AXI4-Lite read channels
   input  wire logic [`ADDR_W-1:0]  araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [`DATA_W-1:0]       rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   // Fetch and return stack
   input  wire rrs_pkg::pc_t        stackHead,
   output logic                     stackPop,
   output logic                     pcLoad,
   output rrs_pkg::pc_t             pcValue,
   // Watchdog and oscillator
   output logic                     wdogClear,
   output logic                     prescClear,
   output logic                     oscStop,
   input  wire logic                wakeReq
);
   import rrs_pkg::*;

   // ****************************************
   // State
   // ****************************************
   state_e                 state_r, stateNxt;
   instr_s                 instr_r, instrNxt;
   flags_s                 flags_r, flagsNxt;
   byte_t                  acc_r, accNxt;
   byte_t                  freg [0:(1<<`FADDR_W)-1];
   logic                   awHeld_r, wHeld_r, bvalid_r, rvalid_r;
   logic [`ADDR_W-1:0]     awAddr_r;
   logic [`DATA_W-1:0]     wData_r, rdata_r;
   logic [3:0]             wStrb_r;
   logic [1:0]             bresp_r, rresp_r;
   logic                   wakeMeta_r, wakeSync_r;
   logic                   pcLoad_r, stackPop_r, oscStop_r;
   logic                   wdogClear_r, prescClear_r;
   pc_t                    pcValue_r;

   // ****************************************
   // Write address decode
   // ****************************************
   wire  stIdle   = state_r == ST_IDLE;
   wire  stExec   = state_r == ST_EXEC;
   wire  doWrite  = awHeld_r && wHeld_r && !bvalid_r;
   wire  wIsInstr = awAddr_r == `ADDR_INSTR;
   wire  wIsAcc   = awAddr_r == `ADDR_ACC;
   wire  wIsStat  = awAddr_r == `ADDR_STAT;
   wire  wIsPc    = awAddr_r == `ADDR_PC;
   wire  wIsFreg  = awAddr_r[`ADDR_W-1:`FREG_SEL_LSB] == `FREG_SEL;
   wire  wMapped  = wIsInstr || wIsAcc || wIsStat || wIsPc || wIsFreg;
   // New instructions are refused until the previous one retires
   wire  issue    = doWrite && wIsInstr && stIdle;
   wire  wLow     = doWrite && wStrb_r[0];
   wire  swAcc    = wLow && wIsAcc;
   wire  swStat   = wLow && wIsStat;
   wire  swFreg   = wLow && wIsFreg;
   wire  [1:0] wResp = (!wMapped || (wIsInstr && !stIdle)) ?
                       `RESP_SLVERR : `RESP_OKAY;
   wire  faddr_t wIdx = awAddr_r[`FREG_IDX_LSB +: `FADDR_W];

   // ****************************************
   // Execution datapath
   // ****************************************
   wire  op_e    curOp  = instr_r.op;
   wire  faddr_t curAdr = instr_r.lit[`FADDR_W-1:0];
   wire  byte_t  fileVal = freg[curAdr];
   wire  isRet  = curOp == RETURN_WITH_LITERAL || curOp == SUB_RETURN;
   wire  isRot  = curOp == ROTATE_RIGHT_CARRY;
   wire  isSlp  = curOp == SLEEP_OP;
   alu_s aluOut;

   rrs_alu i_rrs_alu (
      .op      (curOp),
      .acc     (acc_r),
      .fileVal (fileVal),
      .lit     (instr_r.lit),
      .carryIn (flags_r.carry),
      .res     (aluOut)
   );

   // Hardware updates win over a software write in the same cycle
   wire  accFromInst = stExec && (curOp == RETURN_WITH_LITERAL
                     || curOp == LITERAL_MINUS_ACC
                     || curOp == XOR_LITERAL_ACC
                     || (isRot && !instr_r.dest)); // see RQ4, RQ11
   assign accNxt = accFromInst ? aluOut.value :
                   swAcc ? wData_r[`BYTE_W-1:0] : acc_r; // see RQ1

   // Rotate write-back beats a software file write in the same cycle
   wire  hwFreg    = stExec && isRot && instr_r.dest; // see RQ4
   wire  fregWe    = hwFreg || swFreg;
   wire  faddr_t fregWAdr = hwFreg ? curAdr : wIdx;
   wire  byte_t  fregWDat = hwFreg ? aluOut.value : wData_r[`BYTE_W-1:0];

   // Flags: untouched by returns, only enabled bits move
   assign flagsNxt.carry  = (stExec && aluOut.setC) ? aluOut.carry :
                            swStat ? wData_r[`STAT_C] : flags_r.carry;
   assign flagsNxt.nibble = (stExec && aluOut.setN) ? aluOut.nibble :
                            swStat ? wData_r[`STAT_N] : flags_r.nibble;
   assign flagsNxt.zero   = (stExec && aluOut.setZ) ? aluOut.zero :
                            swStat ? wData_r[`STAT_Z] : flags_r.zero;
   assign flagsNxt.expiry    = (stExec && isSlp) | flags_r.expiry; // see RQ7
   assign flagsNxt.powerDown = !(stExec && isSlp) && flags_r.powerDown;

   assign instrNxt = issue ? instr_s'{op: op_e'(wData_r[`INSTR_OP_LSB +: `OP_W]),
                               dest: wData_r[`INSTR_DEST_BIT],
                               lit:  wData_r[`BYTE_W-1:0]} : instr_r;

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      stateNxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (issue) begin
               stateNxt = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (isRet) begin
               stateNxt = ST_SECOND; // see RQ2, RQ5
            end else if (isSlp) begin
               stateNxt = ST_SLEEP; // see RQ8
            end else begin
               stateNxt = ST_IDLE;
            end
         end
         ST_SECOND: begin
            stateNxt = ST_IDLE;
         end
         ST_SLEEP: begin
            if (wakeSync_r) begin
               stateNxt = ST_IDLE; // see RQ8
            end
         end
         default: begin
            stateNxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         instr_r <= '0;
         acc_r   <= `ACC_RST;
         flags_r <= '{expiry: `EXPIRY_RST, powerDown: `PDOWN_RST,
                      default: 1'b0};
      end else if (ce) begin
         state_r <= stateNxt;
         instr_r <= instrNxt;
         acc_r   <= accNxt;
         flags_r <= flagsNxt;
      end
   end

   // File registers hold no reset, like ordinary RAM
   always_ff @(posedge core_clk) begin
      if (ce && fregWe) begin
         freg[fregWAdr] <= fregWDat;
      end
   end

   // ****************************************
   // Side effects toward fetch, watchdog, clock
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pcLoad_r     <= 1'b0;
         stackPop_r   <= 1'b0;
         pcValue_r    <= `PC_RST;
         wdogClear_r  <= 1'b0;
         prescClear_r <= 1'b0;
         oscStop_r    <= 1'b0;
      end else if (ce) begin
         pcLoad_r     <= stExec && isRet; // see RQ2, RQ5
         stackPop_r   <= stExec && isRet; // see RQ5
         pcValue_r    <= (stExec && isRet) ? stackHead : pcValue_r;
         wdogClear_r  <= stExec && isSlp; // see RQ6
         prescClear_r <= stExec && isSlp; // see RQ6
         oscStop_r    <= stateNxt == ST_SLEEP; // see RQ8
      end
   end

   // Wake pin comes from outside, two flops before use
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wakeMeta_r <= 1'b0;
         wakeSync_r <= 1'b0;
      end else if (ce) begin
         wakeMeta_r <= wakeReq;
         wakeSync_r <= wakeMeta_r;
      end
   end

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   // Ready drops while frozen so no beat is taken and then lost
   assign awready = ce && !awHeld_r && !bvalid_r;
   assign wready  = ce && !wHeld_r && !bvalid_r;
   assign arready = ce && !rvalid_r;

   wire  faddr_t rIdx = araddr[`FREG_IDX_LSB +: `FADDR_W];
   wire  [`DATA_W-1:0] statWord = {{(`DATA_W-`STAT_SLP-1){1'b0}},
                                   state_r == ST_SLEEP, !stIdle,
                                   flags_r.expiry, flags_r.powerDown,
                                   flags_r.zero, flags_r.nibble,
                                   flags_r.carry};
   wire  rIsFreg = araddr[`ADDR_W-1:`FREG_SEL_LSB] == `FREG_SEL;
   wire  rMapped = araddr == `ADDR_INSTR || araddr == `ADDR_ACC
                || araddr == `ADDR_STAT || araddr == `ADDR_PC || rIsFreg;
   wire  [`DATA_W-1:0] rWord =
      araddr == `ADDR_INSTR ? `DATA_W'(instr_r) :
      araddr == `ADDR_ACC   ? `DATA_W'(acc_r) :
      araddr == `ADDR_STAT  ? statWord :
      araddr == `ADDR_PC    ? `DATA_W'(pcValue_r) :
      rIsFreg               ? `DATA_W'(freg[rIdx]) : '0;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         awHeld_r <= 1'b0;
         wHeld_r  <= 1'b0;
         awAddr_r <= '0;
         wData_r  <= '0;
         wStrb_r  <= '0;
         bvalid_r <= 1'b0;
         bresp_r  <= `RESP_OKAY;
      end else if (ce) begin
         if (awvalid && awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= awaddr;
         end else if (doWrite) begin
            awHeld_r <= 1'b0;
         end
         if (wvalid && wready) begin
            wHeld_r <= 1'b1;
            wData_r <= wdata;
            wStrb_r <= wstrb;
         end else if (doWrite) begin
            wHeld_r <= 1'b0;
         end
         if (doWrite) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wResp;
         end else if (bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= `RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rWord;
            rresp_r  <= rMapped ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   assign bvalid     = bvalid_r;
   assign bresp      = bresp_r;
   assign rvalid     = rvalid_r;
   assign rdata      = rdata_r;
   assign rresp      = rresp_r;
   assign pcLoad     = pcLoad_r;
   assign stackPop   = stackPop_r;
   assign pcValue    = pcValue_r;
   assign wdogClear  = wdogClear_r;
   assign prescClear = prescClear_r;
   assign oscStop    = oscStop_r;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   wire  byte_t lit     = instr_r.lit;
   wire  byte_t rotExp  = {flags_r.carry, fileVal[`BYTE_W-1:1]};
   wire  byte_t subExp  = lit - acc_r;
   wire  byte_t xorExp  = lit ^ acc_r;
   wire  noBorrow       = lit >= acc_r;
   wire  nibNoBorrow    = lit[`NIB_W-1:0] >= acc_r[`NIB_W-1:0];
   wire  fileBit0       = fileVal[0];
   wire  run            = ce && stExec;

   property p_retlit_acc; // see RQ1
      run && curOp == RETURN_WITH_LITERAL |=>
         acc_r == $past(lit) && flags_r == $past(flags_r);
   endproperty
   a_retlit_acc: assert property (p_retlit_acc) // see RQ1
      else $error("literal return did not load acc cleanly");

   property p_retlit_pc; // see RQ2
      run && curOp == RETURN_WITH_LITERAL |=>
         pcLoad_r && pcValue_r == $past(stackHead) && state_r == ST_SECOND;
   endproperty
   a_retlit_pc: assert property (p_retlit_pc) // see RQ2
      else $error("literal return did not reload pc over two cycles");

   property p_rot_acc; // see RQ3
      run && isRot && !instr_r.dest |=>
         acc_r == $past(rotExp) && flags_r.carry == $past(fileBit0);
   endproperty
   a_rot_acc: assert property (p_rot_acc) // see RQ3
      else $error("rotate through carry gave a wrong result");

   property p_rot_file; // see RQ4
      run && isRot && instr_r.dest |->
         fregWe && fregWDat == rotExp && fregWAdr == curAdr ##1
         acc_r == $past(acc_r) && freg[$past(curAdr)] == $past(rotExp);
   endproperty
   a_rot_file: assert property (p_rot_file) // see RQ4
      else $error("rotate did not write back to the file register");

   property p_ret_pop; // see RQ5
      run && curOp == SUB_RETURN |=>
         stackPop_r && pcLoad_r && flags_r == $past(flags_r)
         && state_r == ST_SECOND;
   endproperty
   a_ret_pop: assert property (p_ret_pop) // see RQ5
      else $error("subroutine return did not pop the stack");

   property p_sleep_wdog; // see RQ6
      run && isSlp |=> wdogClear_r && prescClear_r;
   endproperty
   a_sleep_wdog: assert property (p_sleep_wdog) // see RQ6
      else $error("sleep did not clear watchdog and prescaler");

   property p_sleep_flags; // see RQ7
      run && isSlp |=> flags_r.expiry && !flags_r.powerDown;
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) // see RQ7
      else $error("sleep left expiry or power-down flag wrong");

   property p_sleep_halt; // see RQ8
      state_r == ST_SLEEP |-> oscStop_r && !issue && !pcLoad_r;
   endproperty
   a_sleep_halt: assert property (p_sleep_halt) // see RQ8
      else $error("core ran while asleep");

   property p_sub; // see RQ9
      run && curOp == LITERAL_MINUS_ACC |=>
         acc_r == $past(subExp) && flags_r.zero == (acc_r == `ACC_RST);
   endproperty
   a_sub: assert property (p_sub) // see RQ9
      else $error("literal minus acc gave a wrong result");

   property p_xor; // see RQ10
      run && curOp == XOR_LITERAL_ACC |=>
         acc_r == $past(xorExp) && flags_r.zero == (acc_r == `ACC_RST)
         && flags_r.carry == $past(flags_r.carry);
   endproperty
   a_xor: assert property (p_xor) // see RQ10
      else $error("xor literal gave a wrong result");

   property p_dest; // see RQ11
      run && isRot |-> fregWe == instr_r.dest && accFromInst != fregWe;
   endproperty
   a_dest: assert property (p_dest) // see RQ11
      else $error("destination select sent the result wrong");

   property p_borrow; // see RQ12
      run && curOp == LITERAL_MINUS_ACC |=>
         flags_r.carry == $past(noBorrow)
         && flags_r.nibble == $past(nibNoBorrow);
   endproperty
   a_borrow: assert property (p_borrow) // see RQ12
      else $error("subtract carry is not the inverted borrow");
endmodule

// ---- test/fetch_stack_model.sv ----
// Model of the fetch unit and hardware return stack
`timescale 1ns/1ps
module fetch_stack_model (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst,
   // Executor side
   input  wire logic         stackPop,
   input  wire logic         pcLoad,
   input  wire rrs_pkg::pc_t pcValue,
   output rrs_pkg::pc_t      stackHead,
   // Program counter as loaded
   output rrs_pkg::pc_t      pcNow
);
   import rrs_pkg::*;
   logic [1:0] sp;
   // Head encodes the depth so a missed pop shows in the next return
   assign stackHead = {sp, 11'h123};
   always @(posedge core_clk) begin
      if (rst) begin
         sp <= 2'h3;
         pcNow <= '0;
      end else begin
         if (stackPop)
            sp <= sp - 2'h1;
         if (pcLoad)
            pcNow <= pcValue;
      end
   end
endmodule

// ---- test/test_return_rotate_sleep_exec.sv ----
// Self-checking bench for the instruction executor
`timescale 1ns/1ps
`include "rrs_cfg.svh"
module test_return_rotate_sleep_exec;
   import rrs_pkg::*;
   logic        core_clk = 0, rst = 1, ce = 1, wakeReq = 0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = '0, rdata, got;
   logic [3:0]  wstrb = 4'hF;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic        stackPop, pcLoad, wdogClear, prescClear, oscStop;
   pc_t         stackHead, pcValue, pcNow;
   int          fail_count = 0, check_count = 0, cyc = 0, nWd = 0, nPs = 0;

   return_rotate_sleep_exec i_return_rotate_sleep_exec (.core_clk, .rst,
      .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .stackHead, .stackPop, .pcLoad, .pcValue,
      .wdogClear, .prescClear, .oscStop, .wakeReq);
   fetch_stack_model i_fetch_stack_model (.core_clk, .rst, .stackPop,
      .pcLoad, .pcValue, .stackHead, .pcNow);

   initial begin
      forever #2 core_clk = ~core_clk;
   end
   // Pulse counters and hang guard
   always @(posedge core_clk) begin
      nWd <= nWd + int'(wdogClear);
      nPs <= nPs + int'(prescClear);
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         close_out();
      end
   end

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, e, input string s);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, s, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er}, "bresp");
   endtask
   task automatic rd(input logic [11:0] a, input logic [1:0] er);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      got = rdata;
      chk({30'h0, rresp}, {30'h0, er}, "rresp");
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                      input string s);
      rd(a, `RESP_OKAY);
      chk(got, e, s);
   endtask
   // Poll busy under a bound; sleep is issued with wr instead
   task automatic ex(input logic [2:0] op, input logic d, input logic [7:0] k);
      wr(`ADDR_INSTR, {17'h0, op, 3'h0, d, k}, `RESP_OKAY);
      repeat (8) begin
         rd(`ADDR_STAT, `RESP_OKAY);
         if (got[`STAT_BUSY] === 1'b0) break;
      end
      chk({31'h0, got[`STAT_BUSY]}, 32'h0, "busy");
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      rdc(`ADDR_STAT, 32'h18, "stat rst");
      rdc(`ADDR_ACC, 32'h00, "acc rst");
      $display("Test reset done");
      wr(`ADDR_ACC, 32'h05, `RESP_OKAY);
      ex(`OP_SUBLIT, 1'b0, 8'h03);
      rdc(`ADDR_ACC, 32'hFE, "sub acc");
      rdc(`ADDR_STAT, 32'h18, "sub borrow");
      ex(`OP_SUBLIT, 1'b0, 8'hFE);
      rdc(`ADDR_ACC, 32'h00, "sub zero");
      rdc(`ADDR_STAT, 32'h1F, "sub no borrow");
      $display("Test subtract done");
      ex(`OP_XORLIT, 1'b0, 8'h0F);
      rdc(`ADDR_ACC, 32'h0F, "xor acc");
      rdc(`ADDR_STAT, 32'h1B, "xor flags");
      ex(`OP_XORLIT, 1'b0, 8'h0F);
      rdc(`ADDR_STAT, 32'h1F, "xor zero");
      $display("Test xor done");
      wr(12'h3FC, 32'h81, `RESP_OKAY);
      ex(`OP_ROTR, 1'b1, 8'h7F);
      rdc(12'h3FC, 32'hC0, "rot freg");
      rdc(`ADDR_ACC, 32'h00, "rot acc kept");
      ex(`OP_ROTR, 1'b0, 8'h7F);
      rdc(`ADDR_ACC, 32'hE0, "rot acc");
      rdc(12'h3FC, 32'hC0, "rot freg kept");
      rdc(`ADDR_STAT, 32'h1E, "rot carry");
      $display("Test rotate done");
      wstrb <= 4'hE;
      wr(`ADDR_ACC, 32'h77, `RESP_OKAY);
      wstrb <= 4'hF;
      rdc(`ADDR_ACC, 32'hE0, "strobe off");
      wr(`ADDR_STAT, 32'hFD, `RESP_OKAY);
      rdc(`ADDR_STAT, 32'h1D, "stat write");
      ex(`OP_RETLIT, 1'b0, 8'hA5);
      rdc(`ADDR_ACC, 32'hA5, "return_with_literal acc");
      rdc(`ADDR_STAT, 32'h1D, "return_with_literal flags");
      rdc(`ADDR_PC, 32'h1923, "return_with_literal pc");
      chk({19'h0, pcNow}, 32'h1923, "return_with_literal load");
      ex(`OP_RETSUB, 1'b0, 8'h00);
      rdc(`ADDR_PC, 32'h1123, "ret pc");
      chk({19'h0, pcNow}, 32'h1123, "ret load");
      rdc(`ADDR_STAT, 32'h1D, "ret flags");
      $display("Test return done");
      rd(12'h100, `RESP_SLVERR);
      chk(got, 32'h0, "unmapped data");
      wr(12'h100, 32'h1, `RESP_SLVERR);
      $display("Test unmapped done");
      wr(`ADDR_INSTR, {17'h0, `OP_SLEEP, 12'h0}, `RESP_OKAY);
      rdc(`ADDR_STAT, 32'h75, "sleep stat");
      chk({31'h0, oscStop}, 32'h1, "osc stop");
      chk(nWd, 1, "wdog clear");
      chk(nPs, 1, "presc clear");
      wr(`ADDR_INSTR, 32'h5000, `RESP_SLVERR);
      wakeReq <= 1'b1;
      repeat (10) if (oscStop === 1'b1) @(posedge core_clk);
      wakeReq <= 1'b0;
      chk({31'h0, oscStop}, 32'h0, "woken");
      rdc(`ADDR_STAT, 32'h15, "wake stat");
      $display("Test sleep done");
      close_out();
   end
endmodule
